// *** spi_port_pkg.sv ***
// Shared types and constants for the serial peripheral port.
// Assumes one core clock domain; pins are sampled inside the port.
package spi_port_pkg;

  // ****************************************************************
  // Sizes and defaults
  // ****************************************************************
  localparam int WORD_W = 8;
  localparam int FIFO_DEPTH = 32;
  localparam int BAUD_W = 8;
  localparam int FLAG_W = 4;
  localparam logic [7:0] BAUD_DIV_RESET = 8'h03;
  localparam int SOD_POS = 5;

  // ****************************************************************
  // Port control word, slave_output_disable at bit 5
  // ****************************************************************
  typedef struct packed {
    logic [1:0] spare;
    logic slave_output_disable;
    logic open_drain_select;
    logic clock_polarity;
    logic clock_phase;
    logic master_en;
    logic port_enable;
  } serial_port_control_s;

  // One two-way pin as seen from the design.
  typedef struct packed {
    logic o;
    logic oe;
  } pin_drive_s;

  // Master sequencer states, one-hot.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_XFER = 2'b10
  } xfer_state_e;

endpackage

// *** tx_fifo.sv ***
// Synchronous FIFO with a registered output stage.
// Assumes both sides run on the same clock.
module tx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic resetn,
  // Fill side.
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Drain side.
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);

  localparam int AW = $clog2(DEPTH);

  // Depth must be a power of two so the pointers wrap freely.
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_bad_depth
    $error("tx_fifo depth must be a power of two of at least 2.");
  end

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic push;
  logic load;

  // The memory accepts while it is not full; the head stage refills.
  assign in_ready = (count_r != AW'(0) + (AW+1)'(DEPTH));
  assign push = in_valid && in_ready;
  assign load = (count_r != '0) && (!out_valid || out_ready);

  // Memory writes.
  always_ff @(posedge sys_clk)
  begin
    if (push)
      mem_r[wr_ptr_r] <= in_data;
  end

  // Pointers and fill level.
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_r <= wr_ptr_r + AW'(1);
      if (load)
        rd_ptr_r <= rd_ptr_r + AW'(1);
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(load);
    end
  end

  // Registered head word, so the reader never sees the array directly.
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      out_valid <= 1'b0;
      out_data <= '0;
    end
    else if (load)
    begin
      out_valid <= 1'b1;
      out_data <= mem_r[rd_ptr_r];
    end
    else if (out_ready)
      out_valid <= 1'b0;
  end

endmodule

// *** spi_port.sv ***
// Serial peripheral port: master or slave shifter with pin control.
// Assumes pins are resolved outside from the output and enable pairs,
// and that all control inputs come from logic on sys_clk.

module spi_port #(
  parameter int WORD_W = spi_port_pkg::WORD_W,
  parameter int FIFO_DEPTH = spi_port_pkg::FIFO_DEPTH,
  parameter int BAUD_W = spi_port_pkg::BAUD_W,
  parameter int FLAG_W = spi_port_pkg::FLAG_W,
  parameter bit MASTER_BOOT = 1'b0
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic resetn,
  // Control.
  input wire spi_port_pkg::serial_port_control_s serial_port_control,
  input wire logic [BAUD_W-1:0] baud_div,
  input wire logic [FLAG_W-1:0] select_mask,
  input wire logic mm_err_clear,
  // Transmit stream.
  input wire logic tx_valid,
  input wire logic [WORD_W-1:0] tx_data,
  output logic tx_ready,
  // Receive stream.
  output logic rx_valid,
  output logic [WORD_W-1:0] rx_data,
  // Status.
  output logic busy,
  output logic mm_err,
  // Serial clock pin.
  input wire logic serial_port_clock_i,
  output spi_port_pkg::pin_drive_s serial_port_clock,
  // Master-out slave-in pin.
  input wire logic mosi_i,
  output spi_port_pkg::pin_drive_s mosi,
  // Master-in slave-out pin.
  input wire logic miso_i,
  output spi_port_pkg::pin_drive_s miso,
  // Slave select input, active low.
  input wire logic slave_select_input_n,
  // Flag pins used as slave selects.
  output logic [FLAG_W-1:0] general_purpose_pins_o,
  output logic [FLAG_W-1:0] general_purpose_pins_oe
);

  localparam int EW = $clog2(2 * WORD_W);
  localparam int BW = $clog2(WORD_W + 1);
  localparam logic [EW-1:0] LAST_EDGE = EW'(2 * WORD_W - 1);
  localparam logic [BW-1:0] LAST_BIT = BW'(WORD_W - 1);

  // Refuse shapes the shifter cannot serve.
  if (WORD_W < 2 || BAUD_W < 1 || FLAG_W < 1)
  begin : g_bad_shape
    $error("spi_port needs WORD_W of 2 or more and nonzero widths.");
  end

  // ****************************************************************
  // Declarations
  // ****************************************************************
  spi_port_pkg::xfer_state_e state_r;
  spi_port_pkg::xfer_state_e state_nxt;
  logic sclk_s1_r, sclk_s2_r, sclk_s3_r;
  logic ss_s1_r, ss_s2_r, ss_s3_r;
  logic mosi_s1_r, mosi_s2_r;
  logic miso_s1_r, miso_s2_r;
  logic [BAUD_W-1:0] div_cnt_r;
  logic [EW-1:0] edge_cnt_r;
  logic [BW-1:0] bit_cnt_r;
  logic sclk_r;
  logic out_r;
  logic need_load_r;
  logic [WORD_W-1:0] tx_sr_r;
  logic [WORD_W-1:0] rx_sr_r;
  logic fifo_valid;
  logic [WORD_W-1:0] fifo_data;
  logic fifo_pop;
  logic is_master, cpol, cpha, tick, xfer, start_m;
  logic lead_m, trail_m, slave_act, ss_fall, lead_s, trail_s;
  logic launch, sample, din, word_done, abort;
  logic sample_now;
  logic [2:0] samp_pipe_r;
  logic [WORD_W-1:0] next_word;

  // ****************************************************************
  // Transmit buffer
  // ****************************************************************
  tx_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_tx_fifo (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .in_valid(tx_valid),
    .in_data(tx_data),
    .in_ready(tx_ready),
    .out_valid(fifo_valid),
    .out_data(fifo_data),
    .out_ready(fifo_pop)
  );

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************

  // Two flops on every pin; the third clock and select flops only feed edge finding.
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sclk_s1_r <= 1'b1;
      sclk_s2_r <= 1'b1;
      sclk_s3_r <= 1'b1;
      ss_s1_r <= 1'b1;
      ss_s2_r <= 1'b1;
      ss_s3_r <= 1'b1;
      mosi_s1_r <= 1'b1;
      mosi_s2_r <= 1'b1;
      miso_s1_r <= 1'b1;
      miso_s2_r <= 1'b1;
    end
    else
    begin
      sclk_s1_r <= serial_port_clock_i;
      sclk_s2_r <= sclk_s1_r;
      sclk_s3_r <= sclk_s2_r;
      ss_s1_r <= slave_select_input_n;
      ss_s2_r <= ss_s1_r;
      ss_s3_r <= ss_s2_r;
      mosi_s1_r <= mosi_i;
      mosi_s2_r <= mosi_s1_r;
      miso_s1_r <= miso_i;
      miso_s2_r <= miso_s1_r;
    end
  end

  // ****************************************************************
  // Edge events
  // ****************************************************************

  // Mode decode and master clock edges.
  assign is_master = serial_port_control.port_enable &&
    serial_port_control.master_en;
  assign cpol = serial_port_control.clock_polarity;
  assign cpha = serial_port_control.clock_phase;
  assign xfer = (state_r == spi_port_pkg::ST_XFER);
  assign tick = xfer && (div_cnt_r == baud_div);
  assign abort = is_master && !ss_s2_r;
  assign start_m = !xfer && is_master && fifo_valid && !abort && !mm_err;
  assign lead_m = tick && (sclk_r == cpol);
  assign trail_m = tick && (sclk_r != cpol);

  // Slave edges count only while selected.
  assign slave_act = serial_port_control.port_enable &&
    !serial_port_control.master_en && !ss_s2_r;
  assign ss_fall = slave_act && ss_s3_r;
  assign lead_s = slave_act && (sclk_s2_r != sclk_s3_r) &&
    (sclk_s2_r != cpol);
  assign trail_s = slave_act && (sclk_s2_r != sclk_s3_r) &&
    (sclk_s2_r == cpol);

  // Launch on one edge, sample on the other, chosen by phase.
  always_comb
  begin
    if (is_master)
    begin
      launch = cpha ? lead_m
        : ((start_m) || (trail_m && edge_cnt_r != LAST_EDGE));
      sample_now = cpha ? trail_m : lead_m;
      din = miso_s2_r;
    end
    else
    begin
      launch = cpha ? lead_s : (ss_fall || trail_s);
      sample_now = cpha ? trail_s : lead_s;
      din = mosi_s2_r;
    end
  end

  // Master samples wait out the pin register and the input synchroniser,
  // so each lands on the return bit as it stood at the pin's edge.
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      samp_pipe_r <= '0;
    else if (!is_master || abort)
      samp_pipe_r <= '0;
    else
      samp_pipe_r <= {samp_pipe_r[1:0], sample_now};
  end

  assign sample = is_master ? samp_pipe_r[2] : sample_now;
  assign word_done = sample && (bit_cnt_r == LAST_BIT);
  assign fifo_pop = launch && need_load_r && fifo_valid;
  assign next_word = fifo_valid ? fifo_data : '0;

  // ****************************************************************
  // Master sequencer
  // ****************************************************************

  // A word runs from start to its last clock edge, then idles.
  always_comb
  begin
    case (state_r)
      spi_port_pkg::ST_IDLE:
        state_nxt = start_m ? spi_port_pkg::ST_XFER
          : spi_port_pkg::ST_IDLE;
      spi_port_pkg::ST_XFER:
        state_nxt = (abort || !is_master ||
          (tick && edge_cnt_r == LAST_EDGE)) ? spi_port_pkg::ST_IDLE
          : spi_port_pkg::ST_XFER;
      default:
        state_nxt = spi_port_pkg::ST_IDLE;
    endcase
  end

  // State register.
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      state_r <= spi_port_pkg::ST_IDLE;
    else
      state_r <= state_nxt;
  end

  // Half-bit divider; a tick is a one-cycle enable.
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      div_cnt_r <= '0;
    else if (!xfer || tick)
      div_cnt_r <= '0;
    else
      div_cnt_r <= div_cnt_r + BAUD_W'(1);
  end

  // Clock toggles twice per bit and rests at the polarity level.
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sclk_r <= 1'b0;
      edge_cnt_r <= '0;
    end
    else if (!xfer)
    begin
      sclk_r <= cpol;
      edge_cnt_r <= '0;
    end
    else if (tick)
    begin
      sclk_r <= ~sclk_r;
      edge_cnt_r <= edge_cnt_r + EW'(1);
    end
  end

  // ****************************************************************
  // Shared shift datapath
  // ****************************************************************

  // Launch side: reload from the buffer at a word boundary.
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      out_r <= 1'b0;
      tx_sr_r <= '0;
      need_load_r <= 1'b1;
    end
    else if ((!is_master && !slave_act) || (is_master && !xfer &&
      !start_m))
      need_load_r <= 1'b1;
    else if (launch)
    begin
      need_load_r <= 1'b0;
      if (need_load_r)
      begin
        out_r <= next_word[WORD_W-1];
        tx_sr_r <= {next_word[WORD_W-2:0], 1'b0};
      end
      else
      begin
        out_r <= tx_sr_r[WORD_W-1];
        tx_sr_r <= {tx_sr_r[WORD_W-2:0], 1'b0};
      end
    end
    else if (is_master ? (tick && edge_cnt_r == LAST_EDGE) : word_done)
      need_load_r <= 1'b1;
  end

  // Sample side: collect bits and hand out full words.
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rx_sr_r <= '0;
      bit_cnt_r <= '0;
      rx_valid <= 1'b0;
      rx_data <= '0;
    end
    else
    begin
      rx_valid <= 1'b0;
      if ((!is_master && !slave_act) ||
        (is_master && !xfer && samp_pipe_r == '0))
        bit_cnt_r <= '0;
      else if (sample)
      begin
        rx_sr_r <= {rx_sr_r[WORD_W-2:0], din};
        bit_cnt_r <= word_done ? '0 : bit_cnt_r + BW'(1);
        if (word_done)
        begin
          rx_valid <= 1'b1;
          rx_data <= {rx_sr_r[WORD_W-2:0], din};
        end
      end
    end
  end

  // ****************************************************************
  // Status
  // ****************************************************************

  // Contention is sticky; a new event beats a clear in the same cycle.
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      mm_err <= 1'b0;
    else if (abort)
      mm_err <= 1'b1;
    else if (mm_err_clear)
      mm_err <= 1'b0;
  end

  // Busy while a master word runs or a slave is selected.
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      busy <= 1'b0;
    else
      busy <= (state_nxt == spi_port_pkg::ST_XFER) || xfer || slave_act;
  end

  // ****************************************************************
  // Pin drivers
  // ****************************************************************

  // Clock and master-out drive only as master, or in reset for boot.
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      serial_port_clock.o <= 1'b0;
      serial_port_clock.oe <= MASTER_BOOT;
      mosi.o <= 1'b0;
      mosi.oe <= MASTER_BOOT;
    end
    else
    begin
      serial_port_clock.o <= xfer ? sclk_r : cpol;
      serial_port_clock.oe <= is_master;
      mosi.o <= out_r;
      mosi.oe <= is_master;
    end
  end

  // Master-in drives only as a selected slave, not when disabled.
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      miso.o <= 1'b0;
      miso.oe <= 1'b0;
    end
    else
    begin
      miso.o <= serial_port_control.open_drain_select ? 1'b0 : out_r;
      miso.oe <= slave_act &&
        !serial_port_control.slave_output_disable &&
        (!serial_port_control.open_drain_select || !out_r);
    end
  end

  // Flag pins act as active-low selects while a master word runs.
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      general_purpose_pins_o <= '1;
      general_purpose_pins_oe <= '0;
    end
    else
    begin
      general_purpose_pins_oe <= is_master ? select_mask : '0;
      general_purpose_pins_o <=
        ((state_nxt == spi_port_pkg::ST_XFER) || busy) ? ~select_mask
        : '1;
    end
  end

endmodule

// *** spi_port_checker.sv ***
// Assertions on the serial port status outputs and pin drives.
// Assumes one sys_clk domain; bound to spi_port at the foot.
module spi_port_checker #(
  parameter bit MASTER_BOOT = 1'b0
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic resetn,
  // Control and status.
  input wire spi_port_pkg::serial_port_control_s serial_port_control,
  input wire logic slave_select_input_n,
  input wire logic rx_valid,
  input wire logic busy,
  input wire logic mm_err,
  // Pin drives.
  input wire spi_port_pkg::pin_drive_s serial_port_clock,
  input wire spi_port_pkg::pin_drive_s mosi,
  input wire spi_port_pkg::pin_drive_s miso
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************
  // Properties
  // ****************
  default clocking dc @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  // Short views of the control word.
  wire [7:0] ctl_w = serial_port_control;
  wire cpol = serial_port_control.clock_polarity;
  wire master = ctl_w[0] & ctl_w[1];
  wire slave = !serial_port_control.master_en;

  idle_level_a: assert property (
    master && !busy && !$past(busy) && $past(resetn) && $stable(ctl_w)
    |-> serial_port_clock.o == cpol) else $error("clock off idle level");
  clock_gated_a: assert property (
    !busy && !$past(busy) && $past(resetn) && $stable(ctl_w) &&
    $past(ctl_w, 2) == ctl_w
    |-> $stable(serial_port_clock.o)) else $error("clock moved while idle");
  mosi_dir_a: assert property ($past(resetn)
    |-> mosi.oe == $past(master) && serial_port_clock.oe == $past(master))
    else $error("master line drive wrong");
  miso_dir_a: assert property ($past(resetn) && $past(master)
    |-> !miso.oe) else $error("return line driven as master");
  miso_off_a: assert property (
    $past(resetn) && $past(ctl_w[spi_port_pkg::SOD_POS]) |-> !miso.oe)
    else $error("return line driven while disabled");
  drain_open_a: assert property ($past(ctl_w[4]) && ctl_w[4]
    |-> !(miso.oe && miso.o)) else $error("open drain drove high");
  mm_detect_a: assert property (
    (master && !slave_select_input_n)[*4] |-> ##[0:4] mm_err)
    else $error("contention not flagged");
  mm_hold_a: assert property (master && mm_err && !busy |=> !busy)
    else $error("word started despite contention");
  deselect_a: assert property (
    (slave && slave_select_input_n)[*6] |-> !rx_valid && !miso.oe)
    else $error("slave active while deselected");
  boot_drive_a: assert property (disable iff (1'b0)
    !resetn && $past(!resetn)
    |-> mosi.oe == MASTER_BOOT && serial_port_clock.oe == MASTER_BOOT)
    else $error("reset drive wrong");

  master_word_c: cover property (master && rx_valid);
  mm_error_c: cover property ($rose(mm_err));
  slave_word_c: cover property (slave && rx_valid);
endmodule

bind spi_port spi_port_checker #(.MASTER_BOOT(MASTER_BOOT)) u_chk (
  .sys_clk(sys_clk), .resetn(resetn),
  .serial_port_control(serial_port_control),
  .slave_select_input_n(slave_select_input_n), .rx_valid(rx_valid),
  .busy(busy), .mm_err(mm_err), .serial_port_clock(serial_port_clock),
  .mosi(mosi), .miso(miso));

// *** spi_slave_model.sv ***
// Behavioural slave device on the far end of the link.
// Assumes its select and lines are resolved in the bench.
module spi_slave_model (
  // Link pins.
  input wire logic sclk,
  input wire logic select_n,
  input wire logic mosi_w,
  output logic miso_o,
  output logic miso_oe,
  // Format and data.
  input wire logic cpol,
  input wire logic cpha,
  input wire logic [7:0] reply,
  output logic [7:0] got,
  output logic [7:0] edges
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] sh;
  logic first;
  initial
  begin
    got = 8'h00;
    edges = 8'h00;
    sh = 8'hFF;
    first = 1'b0;
  end
  // Loads the reply on select; drives only while selected.
  always @(negedge select_n)
  begin
    sh = reply;
    first = cpha;
    edges = 8'h00;
  end
  assign miso_oe = !select_n;
  assign miso_o = sh[7];
  // Samples on one edge and launches on the other, MSB first.
  always @(sclk)
  begin
    if (!select_n)
    begin
      edges = edges + 8'h01;
      if (sclk == !(cpol ^ cpha))
        got = {got[6:0], mosi_w};
      else if (first)
        first = 1'b0;
      else
        sh = {sh[6:0], !sh[7]};
    end
  end
endmodule

// *** tb.sv ***
// Self-checking bench for spi_port with a slave model on the link.
// Assumes package, design and checker files are compiled first.
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  // ****************
  // Wiring
  // ****************
  typedef struct packed {
    logic [1:0] mode;
    logic [7:0] baud;
    logic [7:0] tx;
    logic [7:0] reply;
  } row_s;
  // Format, rate, word sent, slave reply which the port must receive.
  row_s rows [4] = '{'{2'h0, 8'h00, 8'hA5, 8'h3C},
    '{2'h1, 8'h03, 8'h81, 8'hC3}, '{2'h2, 8'h01, 8'h7E, 8'h0F},
    '{2'h3, 8'h00, 8'h01, 8'hF0}};
  logic sys_clk = 1'b0, resetn = 1'b0, tx_valid = 1'b0;
  logic mm_err_clear = 1'b0, ss_n = 1'b1, tb_sclk = 1'b1, tb_mosi = 1'b1;
  logic [7:0] baud_div = 8'h00, tx_data = 8'h00, reply = 8'h00;
  spi_port_pkg::serial_port_control_s ctl = '0;
  logic [7:0] got, edges, mi, rx_data;
  logic tx_ready, rx_valid, busy, mm_err, s_o, s_oe;
  logic [3:0] gp_o, gp_oe;
  spi_port_pkg::pin_drive_s sclk_d, mosi_d, miso_d;
  int num_errors = 0;
  int comparisons = 0;
  // Released return and select lines float high; clock and master-out fall back to tb_sclk and tb_mosi.
  wire sclk_w = sclk_d.oe ? sclk_d.o : tb_sclk;
  wire mosi_w = mosi_d.oe ? mosi_d.o : tb_mosi;
  wire miso_w = miso_d.oe ? miso_d.o : (s_oe ? s_o : 1'b1);
  wire sel_w = gp_oe[0] ? gp_o[0] : 1'b1;
  always #5 sys_clk = ~sys_clk;

  spi_port DUT (.sys_clk(sys_clk), .resetn(resetn),
    .serial_port_control(ctl), .baud_div(baud_div), .select_mask(4'h1),
    .mm_err_clear(mm_err_clear), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
    .busy(busy), .mm_err(mm_err), .serial_port_clock_i(sclk_w),
    .serial_port_clock(sclk_d), .mosi_i(mosi_w), .mosi(mosi_d),
    .miso_i(miso_w), .miso(miso_d), .slave_select_input_n(ss_n),
    .general_purpose_pins_o(gp_o), .general_purpose_pins_oe(gp_oe));
  spi_slave_model far_end (.sclk(sclk_w), .select_n(sel_w),
    .mosi_w(mosi_w), .miso_o(s_o), .miso_oe(s_oe),
    .cpol(ctl.clock_polarity), .cpha(ctl.clock_phase), .reply(reply),
    .got(got), .edges(edges));

  // ****************
  // Tasks
  // ****************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("%0d errors in %0d comparisons", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic send(input logic [7:0] d);
    tx_data = d;
    tx_valid = 1'b1;
    tick(1);
    tx_valid = 1'b0;
  endtask
  // Waits a bounded time for a received word.
  task automatic wait_rx();
    int i;
    for (i = 0; i < 400 && rx_valid !== 1'b1; i++)
      tick(1);
    check({7'h00, rx_valid}, 8'h01);
  endtask
  // Plays an outside master, 125 ns per bit, idle low, MSB first.
  task automatic link_word(input logic sel, input logic [7:0] mo);
    int b;
    tb_sclk = 1'b0;
    ss_n = !sel;
    #500;
    for (b = 7; b >= 0; b--)
    begin
      tb_mosi = mo[b];
      #62.5 tb_sclk = 1'b1;
      mi[b] = miso_w;
      #62.5 tb_sclk = 1'b0;
    end
    tb_mosi = !mo[0];
    #100 ss_n = 1'b1;
    #100 tb_sclk = 1'b1;
    tick(1);
  endtask

  // Cuts a hung run short well after the expected finish.
  initial
  begin
    #200000;
    num_errors++;
    tally_and_finish();
  end
  // Reset, table of master words, then the awkward cases.
  initial
  begin
    int n;
    int i;
    tick(2);
    check({busy, mm_err, tx_ready, mosi_d.oe, sclk_d.oe, miso_d.oe,
      gp_oe[0], rx_valid}, 8'h20);
    resetn = 1'b1;
    ctl.port_enable = 1'b1;
    ctl.master_en = 1'b1;
    foreach (rows[k])
    begin
      {ctl.clock_polarity, ctl.clock_phase} = rows[k].mode;
      baud_div = rows[k].baud;
      reply = rows[k].reply;
      tick(3);
      send(rows[k].tx);
      wait_rx();
      check(rx_data, rows[k].reply);
      check(got, rows[k].tx);
      tick(3);
      check(edges, 8'h10);
      check({7'h00, sclk_w}, {7'h00, rows[k].mode[1]});
    end
    // Contention in mid-word, a refused start, then recovery.
    baud_div = 8'h03;
    reply = 8'h96;
    send(8'h69);
    tick(20);
    ss_n = 1'b0;
    tick(10);
    check({6'h00, busy, mm_err}, 8'h01);
    send(8'h55);
    tick(80);
    check({7'h00, busy}, 8'h00);
    ss_n = 1'b1;
    mm_err_clear = 1'b1;
    tick(6);
    mm_err_clear = 1'b0;
    check({7'h00, mm_err}, 8'h00);
    wait_rx();
    check(rx_data, 8'h96);
    check(got, 8'h55);
    // Port off: the buffer fills until it refuses, then drains.
    ctl = '0;
    tx_valid = 1'b1;
    for (n = 0; n < 40 && tx_ready === 1'b1; n++)
    begin
      tx_data = n[7:0];
      tick(1);
    end
    tx_valid = 1'b0;
    check(n[7:0], 8'h21);
    ctl.port_enable = 1'b1;
    ctl.master_en = 1'b1;
    baud_div = 8'h00;
    n = 0;
    for (i = 0; i < 3000 && n < 33; i++)
    begin
      tick(1);
      if (rx_valid === 1'b1)
        n++;
    end
    check(n[7:0], 8'h21);
    check({7'h00, tx_ready}, 8'h01);
    // Outside master talks to the port as a slave.
    ctl = '0;
    ctl.port_enable = 1'b1;
    ctl.open_drain_select = 1'b1;
    send(8'hA5);
    link_word(1'b1, 8'h3C);
    check(rx_data, 8'h3C);
    check(mi, 8'hA5);
    ctl.open_drain_select = 1'b0;
    ctl.slave_output_disable = 1'b1;
    link_word(1'b1, 8'hC3);
    check(rx_data, 8'hC3);
    check(mi, 8'hFF);
    link_word(1'b0, 8'h0F);
    check(rx_data, 8'hC3);
    tally_and_finish();
  end
endmodule
